// ### design/timer_pwm_module_regs.svh
// Register offsets, field positions and reset values of the timer channel block
`ifndef TIMER_PWM_MODULE_REGS_SVH
`define TIMER_PWM_MODULE_REGS_SVH

`define NUM_CHANNELS 2
`define CNT_W 16
`define ADDR_W 12

// ==========================================
// Register byte offsets
`define OFS_STATUS_CONTROL 12'h000
`define OFS_COUNTER_VALUE 12'h004
`define OFS_MODULO_VALUE 12'h008
`define OFS_CHANNEL_BASE 12'h010
`define OFS_CHANNEL_STRIDE 12'h008
`define OFS_CHANNEL_VALUE 12'h004

// ==========================================
// Field positions
`define FLD_FLAG 7
`define FLD_CENTER 5
`define FLD_CLKS_HI 4
`define FLD_CLKS_LO 3
`define FLD_PS_HI 2
`define FLD_PS_LO 0
`define FLD_MODE_HI 5
`define FLD_MODE_LO 4
`define FLD_ELS_HI 3
`define FLD_ELS_LO 2

// ==========================================
// Reset values
`define RST_CNT 16'h0000
`define RST_MOD 16'h0000
`define RST_CTRL 8'h00

`endif

// ### design/timer_pwm_module_pkg.sv
// Types shared by the timer channel block and its bench
package timer_pwm_module_pkg;

    typedef enum logic [1:0] {CLK_NONE, CLK_BUS, CLK_FIXED, CLK_EXTERNAL} clock_source_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [1:0] channel_mode_select;
        logic [1:0] edge_level_select;
    } channel_cfg_t;

endpackage : timer_pwm_module_pkg

// ### design/timer_pwm_module.sv
// Timer/PWM module: counter, clock source choice, per-channel capture, compare and PWM pin logic
`timescale 1ns/1ps
`include "timer_pwm_module_regs.svh"
// ==========================================
module timer_pwm_module (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire timer_pwm_module_pkg::apb_req_t i_apb,
    output timer_pwm_module_pkg::apb_rsp_t o_apb,
    input wire logic i_fixed_clock_tick,
    input wire logic i_external_count_clock,
    input wire logic [`NUM_CHANNELS-1:0] i_channel_pin,
    output logic [`NUM_CHANNELS-1:0] o_channel_pin,
    output logic [`NUM_CHANNELS-1:0] o_channel_pin_oe,
    output logic [`NUM_CHANNELS-1:0] o_channel_owned
);

    // ==========================================
    // Bus decode
    logic setup;
    logic wr_en;
    logic [`ADDR_W-1:0] addr;
    assign setup = i_apb.psel && !i_apb.penable;
    assign wr_en = i_apb.psel && i_apb.penable && i_apb.pwrite;
    assign addr = i_apb.paddr;

    // ==========================================
    // Global control and counter
    logic [7:0] ctrl_q, ctrl_d;
    logic [`CNT_W-1:0] cnt_q, cnt_d, mod_q, mod_d;
    logic up_q, up_d;
    logic new_q, new_d;
    logic [6:0] pre_q, pre_d;
    logic [2:0] ext_q, ext_d;
    logic tick;
    logic src_tick;
    logic center;
    logic ovf;
    timer_pwm_module_pkg::clock_source_t clks;

    assign center = ctrl_q[`FLD_CENTER];
    assign clks = timer_pwm_module_pkg::clock_source_t'(ctrl_q[`FLD_CLKS_HI:`FLD_CLKS_LO]);

    always_comb begin
        // First flop only feeds the second; edges are taken between second and third
        ext_d = {ext_q[1:0], i_external_count_clock};
        unique case (clks)
            timer_pwm_module_pkg::CLK_NONE: src_tick = 1'b0;
            timer_pwm_module_pkg::CLK_BUS: src_tick = 1'b1;
            timer_pwm_module_pkg::CLK_FIXED: src_tick = i_fixed_clock_tick;
            timer_pwm_module_pkg::CLK_EXTERNAL: src_tick = ext_q[1] && !ext_q[2];
        endcase
        pre_d = pre_q;
        tick = 1'b0;
        if (src_tick) begin
            tick = (pre_q & ((7'h01 << ctrl_q[`FLD_PS_HI:`FLD_PS_LO]) - 7'h01))
                == ((7'h01 << ctrl_q[`FLD_PS_HI:`FLD_PS_LO]) - 7'h01);
            pre_d = tick ? 7'h00 : pre_q + 7'h01;
        end
        cnt_d = cnt_q;
        up_d = up_q;
        ovf = 1'b0;
        if (tick) begin
            if (center) begin
                // Modulo of zero leaves the up/down counter parked at zero
                if (up_q && cnt_q >= mod_q) begin
                    up_d = 1'b0;
                    cnt_d = (mod_q == 16'h0000) ? 16'h0000 : cnt_q - 16'h0001;
                end else if (!up_q && cnt_q == 16'h0000) begin
                    up_d = 1'b1;
                    ovf = 1'b1;
                    cnt_d = (mod_q == 16'h0000) ? 16'h0000 : 16'h0001;
                end else begin
                    cnt_d = up_q ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
                end
            end else begin
                up_d = 1'b1;
                if (mod_q != 16'h0000 && cnt_q == mod_q) begin
                    cnt_d = 16'h0000;
                    ovf = 1'b1;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                    ovf = (cnt_q == 16'hffff);
                end
            end
        end
        new_d = tick;
        ctrl_d = ctrl_q;
        mod_d = mod_q;
        if (wr_en && addr == `OFS_STATUS_CONTROL) begin
            ctrl_d[6:0] = i_apb.pwdata[6:0];
            if (!i_apb.pwdata[`FLD_FLAG]) begin
                ctrl_d[`FLD_FLAG] = 1'b0;
            end
        end
        if (wr_en && addr == `OFS_MODULO_VALUE) begin
            mod_d = i_apb.pwdata[15:0];
        end
        // Setting the flag after the clear keeps an overflow in the clearing cycle
        if (ovf) begin
            ctrl_d[`FLD_FLAG] = 1'b1;
        end
        // Any counter write restarts the count and the prescaler, whatever the data
        if (wr_en && addr == `OFS_COUNTER_VALUE) begin
            cnt_d = `RST_CNT;
            pre_d = 7'h00;
            up_d = 1'b1;
            new_d = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ctrl_q <= `RST_CTRL;
            cnt_q <= `RST_CNT;
            mod_q <= `RST_MOD;
            up_q <= 1'b1;
            new_q <= 1'b0;
            pre_q <= 7'h00;
            ext_q <= 3'h0;
        end else begin
            ctrl_q <= ctrl_d;
            cnt_q <= cnt_d;
            mod_q <= mod_d;
            up_q <= up_d;
            new_q <= new_d;
            pre_q <= pre_d;
            ext_q <= ext_d;
        end
    end

    // ==========================================
    // Channels
    logic [7:0] ch_ctrl_rd [`NUM_CHANNELS];
    logic [`CNT_W-1:0] ch_val_rd [`NUM_CHANNELS];

    genvar n;
    generate
        for (n = 0; n < `NUM_CHANNELS; n++) begin : g_ch
            localparam logic [`ADDR_W-1:0] CH_OFS = `ADDR_W'(`OFS_CHANNEL_BASE + `OFS_CHANNEL_STRIDE * n);
            timer_pwm_module_pkg::channel_cfg_t cfg_q, cfg_d;
            logic flag_q, flag_d;
            logic [`CNT_W-1:0] val_q, val_d;
            logic [2:0] pin_q, pin_d;
            logic out_q, out_d;
            logic owned, drives, match, capture, rise, fall, low_true;

            always_comb begin
                pin_d = {pin_q[1:0], i_channel_pin[n]};
                rise = pin_q[1] && !pin_q[2];
                fall = !pin_q[1] && pin_q[2];
                low_true = cfg_q.edge_level_select[0];
                owned = (cfg_q.edge_level_select != 2'b00) && (clks != timer_pwm_module_pkg::CLK_NONE);
                drives = owned && (center || cfg_q.channel_mode_select != 2'b00);
                match = new_q && (cnt_q == val_q);
                capture = 1'b0;
                if (!center && cfg_q.channel_mode_select == 2'b00) begin
                    unique case (cfg_q.edge_level_select)
                        2'b00: capture = 1'b0;
                        2'b01: capture = rise;
                        2'b10: capture = fall;
                        2'b11: capture = rise || fall;
                    endcase
                end
                // An undriven pin keeps tracking its level so toggle mode starts from it
                out_d = drives ? out_q : pin_q[1];
                if (drives && center) begin
                    if (match) begin
                        out_d = up_q ? low_true : !low_true;
                    end
                end else if (drives && cfg_q.channel_mode_select[1]) begin
                    // Match after period start: a channel value of zero gives zero duty
                    if (new_q && cnt_q == 16'h0000) begin
                        out_d = !low_true;
                    end
                    if (match) begin
                        out_d = low_true;
                    end
                end else if (drives && match) begin
                    unique case (cfg_q.edge_level_select)
                        2'b01: out_d = !out_q;
                        2'b10: out_d = 1'b0;
                        2'b11: out_d = 1'b1;
                        default: out_d = out_q;
                    endcase
                end
                cfg_d = cfg_q;
                flag_d = flag_q;
                val_d = val_q;
                if (wr_en && addr == CH_OFS) begin
                    cfg_d = i_apb.pwdata[`FLD_MODE_HI:`FLD_ELS_LO];
                    if (!i_apb.pwdata[`FLD_FLAG]) begin
                        flag_d = 1'b0;
                    end
                end
                if (wr_en && addr == CH_OFS + `OFS_CHANNEL_VALUE) begin
                    val_d = i_apb.pwdata[15:0];
                end
                if (capture) begin
                    val_d = cnt_q;
                end
                // Compare keeps flagging with pins released, giving a software timer
                if (capture || (match && (center || cfg_q.channel_mode_select != 2'b00))) begin
                    flag_d = 1'b1;
                end
            end

            always_ff @(posedge i_clock) begin
                if (i_rst) begin
                    cfg_q <= '0;
                    flag_q <= 1'b0;
                    val_q <= 16'h0000;
                    pin_q <= 3'h0;
                    out_q <= 1'b0;
                end else begin
                    cfg_q <= cfg_d;
                    flag_q <= flag_d;
                    val_q <= val_d;
                    pin_q <= pin_d;
                    out_q <= out_d;
                end
            end

            assign o_channel_pin[n] = out_q;
            assign o_channel_pin_oe[n] = drives;
            assign o_channel_owned[n] = owned;
            assign ch_ctrl_rd[n] = {flag_q, 1'b0, cfg_q, 2'b00};
            assign ch_val_rd[n] = val_q;
        end
    endgenerate

    // ==========================================
    // Read path, latched in the setup cycle so the access phase needs no wait
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;

    always_comb begin
        rdata_d = rdata_q;
        err_d = err_q;
        if (setup) begin
            rdata_d = 32'h0000_0000;
            err_d = 1'b0;
            unique case (addr)
                `OFS_STATUS_CONTROL: rdata_d[7:0] = ctrl_q;
                `OFS_COUNTER_VALUE: rdata_d[15:0] = cnt_q;
                `OFS_MODULO_VALUE: rdata_d[15:0] = mod_q;
                default: err_d = 1'b1;
            endcase
            for (int k = 0; k < `NUM_CHANNELS; k++) begin
                if (addr == `ADDR_W'(`OFS_CHANNEL_BASE + `OFS_CHANNEL_STRIDE * k)) begin
                    rdata_d[7:0] = ch_ctrl_rd[k];
                    err_d = 1'b0;
                end
                if (addr == `ADDR_W'(`OFS_CHANNEL_BASE + `OFS_CHANNEL_STRIDE * k + `OFS_CHANNEL_VALUE)) begin
                    rdata_d[15:0] = ch_val_rd[k];
                    err_d = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    assign o_apb.prdata = rdata_q;
    assign o_apb.pready = 1'b1;
    assign o_apb.pslverr = err_q && i_apb.psel && i_apb.penable;

endmodule : timer_pwm_module

// ### verif/timer_pwm_module_checker.sv
// Port-level assertions for the timer channel block
`timescale 1ns/1ps
module timer_pwm_module_checker (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire timer_pwm_module_pkg::apb_req_t i_apb,
    input wire timer_pwm_module_pkg::apb_rsp_t o_apb,
    input wire logic i_fixed_clock_tick,
    input wire logic i_external_count_clock,
    input wire logic [1:0] i_channel_pin,
    input wire logic [1:0] o_channel_pin,
    input wire logic [1:0] o_channel_pin_oe,
    input wire logic [1:0] o_channel_owned
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    // ==========================================
    // Bus side
    chk_ready_high: assert property (o_apb.pready)
        else $error("pready low");
    chk_err_idle: assert property (!(i_apb.psel && i_apb.penable) |-> !o_apb.pslverr)
        else $error("pslverr outside access");
    chk_err_mapped: assert property (i_apb.psel && i_apb.penable && i_apb.paddr inside {12'h000, 12'h004, 12'h008,
        12'h010, 12'h014, 12'h018, 12'h01c} |-> !o_apb.pslverr) else $error("mapped access refused");
    chk_err_unmapped: assert property (i_apb.psel && i_apb.penable && !i_apb.pwrite && i_apb.paddr == 12'h0f0
        |-> o_apb.pslverr && o_apb.prdata == 32'h0) else $error("unmapped read not refused");
    chk_data_hold: assert property (!(i_apb.psel && !i_apb.penable) |=> $stable(o_apb.prdata))
        else $error("prdata moved outside setup");
    // ==========================================
    // Pin ownership
    chk_oe_owned: assert property ((o_channel_pin_oe & ~o_channel_owned) == 2'h0)
        else $error("pin driven but not owned");
    chk_owned_write: assert property (!$stable(o_channel_owned) |-> $past(i_apb.psel && i_apb.penable && i_apb.pwrite))
        else $error("ownership changed without write");
    chk_oe_write: assert property ($changed(o_channel_pin_oe) |-> $past(i_apb.pwrite && i_apb.penable))
        else $error("drive changed without write");
    chk_reset_quiet: assert property ($fell(i_rst) |-> o_channel_owned == 2'h0 && o_channel_pin_oe == 2'h0)
        else $error("pins owned after reset");
    // Released pin must keep reflecting the wire so toggle mode starts from it
    chk_pin_follow: assert property ((!o_channel_pin_oe[0] && $stable(i_channel_pin[0])) [*5]
        |-> o_channel_pin[0] == i_channel_pin[0])
        else $error("released pin level lost");
    cover property (o_channel_pin_oe[0] && $rose(o_channel_pin[0]));
    cover property (o_apb.pslverr);
    cover property (o_channel_owned[0] && !o_channel_pin_oe[0]);
endmodule : timer_pwm_module_checker

// ### verif/timer_pin_partner.sv
// Far-side model: drivers on the channel pins and the external count clock
`timescale 1ns/1ps
module timer_pin_partner (
    input wire logic i_clock,
    input wire logic [1:0] i_pin_out,
    input wire logic [1:0] i_pin_oe,
    output logic [1:0] o_pin_level,
    output logic o_ext_clock
);
    logic [1:0] drive_q = 2'h0;
    initial o_ext_clock = 1'b0;
    // A pin the block drives shows its level, otherwise ours
    assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & drive_q);
    task set_pin(input int ch, input logic v);
        @(posedge i_clock);
        drive_q[ch] <= v;
    endtask : set_pin
    // Eight bus cycles a period keeps the source well under the quarter-rate limit
    task ext_edges(input int n);
        repeat (n) begin
            @(posedge i_clock);
            o_ext_clock <= 1'b1;
            repeat (4) @(posedge i_clock);
            o_ext_clock <= 1'b0;
            repeat (3) @(posedge i_clock);
        end
    endtask : ext_edges
endmodule : timer_pin_partner

// ### verif/timer_pwm_module_tb.sv
// Self-checking bench for the timer channel block
`timescale 1ns/1ps
module timer_pwm_module_tb;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic i_fixed_clock_tick = 1'b0;
    timer_pwm_module_pkg::apb_req_t i_apb = '0;
    timer_pwm_module_pkg::apb_rsp_t o_apb;
    logic ext_clock;
    logic [1:0] pin_level, pin_out, pin_oe, owned;
    logic [31:0] rd;
    logic err;
    int error_cnt = 0;
    int samples_checked = 0;
    int hi, tg;
    always #2 i_clock = ~i_clock;
    timer_pwm_module i_timer_pwm_module (.i_clock(i_clock), .i_rst(i_rst), .i_apb(i_apb), .o_apb(o_apb),
        .i_fixed_clock_tick(i_fixed_clock_tick), .i_external_count_clock(ext_clock),
        .i_channel_pin(pin_level), .o_channel_pin(pin_out), .o_channel_pin_oe(pin_oe), .o_channel_owned(owned));
    timer_pin_partner i_timer_pin_partner (.i_clock(i_clock), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
        .o_pin_level(pin_level), .o_ext_clock(ext_clock));
    // ==========================================
    // Tasks
    task report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clock);
        i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge i_clock);
        i_apb.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_apb.pready !== 1'b1 && n < 20);
        if (o_apb.pready !== 1'b1) begin
            error_cnt++;
            report_and_stop();
        end else begin
            rd = o_apb.prdata;
            err = o_apb.pslverr;
            i_apb <= '0;
        end
    endtask : apb
    task do_reset();
        @(posedge i_clock);
        i_rst <= 1'b1;
        repeat (10) @(posedge i_clock);
        i_rst <= 1'b0;
    endtask : do_reset
    // Counts high samples and level changes of one pin over n cycles
    task run(input int ch, input int n);
        logic prev;
        hi = 0;
        tg = 0;
        prev = pin_out[ch];
        repeat (n) begin
            @(posedge i_clock);
            if (pin_out[ch] === 1'b1) hi++;
            if (pin_out[ch] !== prev) tg++;
            prev = pin_out[ch];
        end
    endtask : run
    // ==========================================
    // Sequence
    initial begin
        do_reset();
        apb(0, 12'h010, 0);
        chk("chan_ctrl", rd, 32'h0);
        chk("owned", owned, 32'h0);
        apb(0, 12'h0f0, 0);
        chk("unmapped_err", err, 32'h1);
        $display("test reset_and_map done");
        for (int p = 0; p < 4; p++) begin
            // Edge PWM for p<2, center PWM with compare mode bits for p>=2
            do_reset();
            apb(1, 12'h008, 8);
            apb(1, 12'h014, 5);
            apb(1, 12'h010, (p < 2) ? (p[0] ? 8'h24 : 8'h28) : (p[0] ? 8'h14 : 8'h18));
            apb(1, 12'h000, (p < 2) ? 8'h08 : 8'h28);
            repeat (20) @(posedge i_clock);
            // Whole periods only: nine counts per edge period, sixteen per center period
            run(0, (p < 2) ? 36 : 32);
            chk("pwm_high", hi, (p < 2) ? (p[0] ? 16 : 20) : (p[0] ? 12 : 20));
            chk("pwm_owned", {pin_oe, owned}, 32'h5);
        end
        $display("test pwm done");
        do_reset();
        i_timer_pin_partner.set_pin(0, 1'b1);
        apb(1, 12'h008, 8);
        apb(1, 12'h014, 3);
        apb(1, 12'h010, 8'h14);
        repeat (4) @(posedge i_clock);
        chk("stopped_owned", owned[0], 32'h0);
        apb(1, 12'h000, 8'h08);
        @(posedge i_clock);
        chk("toggle_start", {pin_oe[0], pin_out[0]}, 32'h3);
        run(0, 18);
        chk("toggle_count", tg, 32'h2);
        for (int c = 2; c < 4; c++) begin
            apb(1, 12'h010, 8'h10 | (c << 2));
            repeat (12) @(posedge i_clock);
            chk("compare_level", pin_out[0], c & 1);
        end
        $display("test compare done");
        do_reset();
        i_timer_pin_partner.set_pin(0, 1'b0);
        apb(1, 12'h000, 8'h08);
        for (int c = 1; c < 4; c++) begin
            apb(1, 12'h010, c << 2);
            i_timer_pin_partner.set_pin(0, 1'b1);
            repeat (6) @(posedge i_clock);
            apb(0, 12'h010, 0);
            chk("rise_flag", rd[7], c & 1);
            apb(1, 12'h010, c << 2);
            i_timer_pin_partner.set_pin(0, 1'b0);
            repeat (6) @(posedge i_clock);
            apb(0, 12'h010, 0);
            chk("fall_flag", rd[7], c >> 1);
        end
        chk("capture_pin", {pin_oe[0], owned[0]}, 32'h1);
        apb(1, 12'h010, 8'h04);
        i_timer_pin_partner.set_pin(0, 1'b1);
        repeat (3) @(posedge i_clock);
        i_timer_pin_partner.set_pin(0, 1'b0);
        repeat (6) @(posedge i_clock);
        apb(0, 12'h010, 0);
        chk("short_pulse", rd[7], 32'h1);
        $display("test capture done");
        do_reset();
        apb(1, 12'h014, 2);
        apb(1, 12'h010, 8'h10);
        for (int k = 0; k < 4; k++) begin
            if (k == 1) continue;
            // Clearing the channel flag first shows the fixed and external sources each drive the software timer on their own
            apb(1, 12'h010, 8'h10);
            apb(1, 12'h000, k << 3);
            apb(1, 12'h004, 0);
            repeat (3) begin
                @(posedge i_clock);
                i_fixed_clock_tick <= 1'b1;
                @(posedge i_clock);
                i_fixed_clock_tick <= 1'b0;
            end
            i_timer_pin_partner.ext_edges(3);
            repeat (6) @(posedge i_clock);
            apb(0, 12'h004, 0);
            chk("source_count", rd, (k == 0) ? 0 : 3);
            apb(0, 12'h010, 0);
            chk("soft_timer", {owned[0], rd[7]}, (k == 0) ? 0 : 1);
        end
        // Bus clock divided by four: 42 cycles from the restart to the latched read
        apb(1, 12'h000, 8'h0a);
        apb(1, 12'h004, 0);
        repeat (40) @(posedge i_clock);
        apb(0, 12'h004, 0);
        chk("prescaled_count", rd, 32'h0000000a);
        $display("test clock_source done");
        report_and_stop();
    end
endmodule : timer_pwm_module_tb
bind timer_pwm_module timer_pwm_module_checker i_timer_pwm_module_checker (.i_clock(i_clock), .i_rst(i_rst),
    .i_apb(i_apb), .o_apb(o_apb), .i_fixed_clock_tick(i_fixed_clock_tick),
    .i_external_count_clock(i_external_count_clock), .i_channel_pin(i_channel_pin), .o_channel_pin(o_channel_pin),
    .o_channel_pin_oe(o_channel_pin_oe), .o_channel_owned(o_channel_owned));
